// [src/asr_params.svh]
// Constants for the angle / status / error register group: offsets, field
// positions, codes and reset values. Definitions only; no logic.
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// Byte addresses on the serial register port (word at even address)
`define ASR_OFS_CTRL      6'h1E
`define ASR_OFS_TRIG      6'h1F
`define ASR_OFS_ANG       6'h20
`define ASR_OFS_STA       6'h22
`define ASR_OFS_ERR       6'h24

// Register id nibbles in bits 15:12
`define ASR_ID_STA        4'h8
`define ASR_ID_ERR        4'hA

// Trigger byte values
`define ASR_TRIG_SELFTEST 8'hB9
`define ASR_TRIG_TURNS    8'h46
`define ASR_TRIG_HARD     8'h5A

// Action selector values
`define ASR_SEL_TURNS     4'h4
`define ASR_SEL_HARD      4'h7
`define ASR_SEL_FRONTEND  4'h9
`define ASR_SEL_LOGIC     4'hA
`define ASR_SEL_BOTH      4'hB

// Control byte (high byte of the control word) field positions
`define ASR_CTRL_SEL_HI   7
`define ASR_CTRL_SEL_LO   4
`define ASR_CTRL_CLS      2
`define ASR_CTRL_CLW      1
`define ASR_CTRL_CLE      0

// Error flag count and reset value (reset flag set after power-on)
`define ASR_ERR_BITS      12
`define ASR_ERR_RESET     12'h001
`define ASR_ERR_WAR       11
`define ASR_ERR_UVD       3
`define ASR_ERR_UVA       2

// Serial frame length in rising link clock edges
`define ASR_FRAME_BITS    5'h10

`endif

// [src/asr_pkg.sv]
// Types shared by the angle / status / error register group.
// Assumes asr_params.svh supplies the numeric constants.
package asr_pkg;

  // One decoded host frame: write flag, byte address, write data
  typedef struct packed {
    logic       write;
    logic [5:0] addr;
    logic [7:0] data;
  } asr_frame_s;

  // Latched error conditions, most significant bit is the warning summary
  typedef struct packed {
    logic warning_summary;
    logic selftest_failure;
    logic averaging_error;
    logic quadrature_integrity_fault;
    logic loop_lock_lost;
    logic zero_crossing_timeout;
    logic nvm_uncorrectable_error;
    logic oscillator_watchdog_error;
    logic supply_undervoltage;
    logic regulator_undervoltage;
    logic field_low_fault;
    logic reset_event;
  } asr_err_s;

  // Kind of action_selector action launched
  typedef enum logic [1:0] {
    ASR_ACT_NONE     = 2'b00,
    ASR_ACT_SELFTEST = 2'b01,
    ASR_ACT_TURNS    = 2'b10,
    ASR_ACT_HARD     = 2'b11
  } asr_action_e;

  // Action_selector-action sequencer state
  typedef enum logic {
    ASR_IDLE = 1'b0,
    ASR_BUSY = 1'b1
  } asr_act_state_e;

endpackage

// [src/asr_link.sv]
// Serial register port slave: 16-bit frames, MSB first, data sampled on the
// rising link clock edge and shifted out on the falling edge, select low.
// Assumes link pins are asynchronous to clock and run far slower than it.
`timescale 1ns/1ps
`default_nettype none
`include "asr_params.svh"

module asr_link
  import asr_pkg::*;
(
  input  wire logic        clock,       // System clock
  input  wire logic        sys_rst,     // Synchronous reset, active high
  input  wire logic        link_sclk,   // Host link clock pin
  input  wire logic        link_cs_n,   // Host select pin, active low
  input  wire logic        link_mosi,   // Host data in
  input  wire logic [15:0] tx_word,     // Word to return in next frame
  output logic             miso_out,    // Data out level
  output logic             miso_oe,     // Data out enable
  output logic             frame_valid, // One-cycle pulse per good frame
  output asr_frame_s       frame        // Decoded frame
);

  logic [2:0]  sclk_s;
  logic [2:0]  cs_s;
  logic [1:0]  mosi_s;
  logic [4:0]  bit_cnt;
  logic [15:0] rx_sh;
  logic [15:0] tx_sh;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_active;
  logic        cs_fall;
  logic        cs_rise;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; stage three only for edge finding
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclk_s <= 3'h0;
      cs_s   <= 3'h7;
      mosi_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], link_sclk};
      cs_s   <= {cs_s[1:0], link_cs_n};
      mosi_s <= {mosi_s[0], link_mosi};
    end
  end

  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2];
  assign cs_active = ~cs_s[1];
  assign cs_fall   = ~cs_s[1] & cs_s[2];
  assign cs_rise   = cs_s[1] & ~cs_s[2];

  ////////////////////////////////////////////////////////////////////////
  // Shift registers; bit count saturates so long frames are dropped
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bit_cnt <= 5'h00;
      rx_sh   <= 16'h0000;
      tx_sh   <= 16'h0000;
    end else if (cs_fall) begin
      bit_cnt <= 5'h00;
      tx_sh   <= tx_word;
    end else if (cs_active && sclk_rise) begin
      rx_sh <= {rx_sh[14:0], mosi_s[1]};
      if (bit_cnt != 5'h1F) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end else if (cs_active && sclk_fall && bit_cnt != 5'h00) begin
      tx_sh <= {tx_sh[14:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame accepted at select release only if exactly 16 bits, bit 15 clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frame_valid <= 1'b0;
      frame       <= '0;
      miso_out    <= 1'b0;
      miso_oe     <= 1'b0;
    end else begin
      frame_valid <= cs_rise && bit_cnt == `ASR_FRAME_BITS && !rx_sh[15];
      if (cs_rise) begin
        frame <= rx_sh[14:0];
      end
      miso_out <= cs_active & tx_sh[15];
      miso_oe  <= cs_active;
    end
  end

endmodule // asr_link
`default_nettype wire

// [src/asr_err_bank.sv]
// Bank of latched error flags with read tracking: a clear removes only the
// flags returned by the last capture. Assumes capture and clear are pulses.
`timescale 1ns/1ps
`default_nettype none

module asr_err_bank #(
  parameter int          N         = 12,         // Number of flags
  parameter logic [N-1:0] RESET_VAL = '0         // Flags set by reset
) (
  input  wire logic         clock,   // System clock
  input  wire logic         sys_rst, // Synchronous reset, active high
  input  wire logic [N-1:0] set_in,  // Live set conditions
  input  wire logic         capture, // Register read returned flags
  input  wire logic         clear,   // Clear request
  output logic      [N-1:0] flags    // Latched flags
);

  logic [N-1:0] seen;

  ////////////////////////////////////////////////////////////////////////
  // One latch and one read-tracking bit per flag; set beats clear
  for (genvar i = 0; i < N; i++) begin : g_flag
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        flags[i] <= RESET_VAL[i];
      end else begin
        flags[i] <= set_in[i] | (flags[i] & ~(clear & seen[i]));
      end
    end

    always_ff @(posedge clock) begin
      if (sys_rst) begin
        seen[i] <= 1'b0;
      end else if (capture) begin
        seen[i] <= flags[i];
      end else if (clear) begin
        seen[i] <= 1'b0;
      end
    end
  end

endmodule // asr_err_bank
`default_nettype wire

// [src/asr_regs.sv]
// Angle, status and error register group of the angle sensor, reached
// over the serial register port, plus the action_selector-action trigger decode.
// Assumes datapath inputs are on clock; link pins are asynchronous.
//
// Functional notes
// - Trigger byte after selector launches self-test, turns reset or hard reset; reads zero.
// - Angle word: bit15 zero, flags in 14:13, parity in 12, processed angle in 11:0.
// - Error summary set when any unmasked error or warning flag is set.
// - Undervoltage bit is live masked OR of supply and regulator detectors.
// - Parity bit makes the whole angle word hold odd ones.
// - Status word id nibble 1000, error word id nibble 1010.
// - Status shows two-bit die identifier loaded from nonvolatile memory.
// - Rotation bit: 0 increasing, 1 decreasing, from hysteresis logic.
// - Action_selector-done clears on trigger, sets on completion, cleared by status-clear.
// - Boot-done sets after load and start-up tests; status-clear clears it.
// - Status bits 3 and 2 show logic and front-end self-tests running.
// - Bit 1 shows boot in progress; bit 0 shows locked and started.
// - Error flags latch; host reads then clears to expose later errors.
// - Error bit 11 latches unmasked warnings; mask may suppress it.
// - Error bit 10 latches either self-test failure.
// - Error bit 9 latches averaging count too large for speed.
// - Error bit 8 quadrature integrity loss; bit 7 tracking loop lock loss.
// - Error bit 6 latches missing zero-crossing within maximum interval.
// - Error bit 5 uncorrectable memory error at load; bit 4 oscillator watchdog.
// - Error bits 3 and 2 undervoltage keep setting while fault persists.
// - Error bit 1 latches field below low threshold.
// - Error bit 0 sets on power-on or hard reset, not logic self-test.
// - Error-clear removes only flags returned by an earlier error read.
// - Status-clear write clears action_selector-done and boot-done.
`timescale 1ns/1ps
`default_nettype none
`include "asr_params.svh"

module asr_regs
  import asr_pkg::*;
(
  input  wire logic        clock,             // System clock, 250 MHz
  input  wire logic        sys_rst,           // Synchronous reset, power-on
  input  wire logic        link_sclk,         // Host link clock pin
  input  wire logic        link_cs_n,         // Host select, active low
  input  wire logic        link_mosi,         // Host data in
  output logic             link_miso_out,     // Host data out level
  output logic             link_miso_oe,      // Host data out enable
  input  wire logic [11:0] angle_value,       // Processed angle
  input  wire asr_err_s    err_cond,          // Live error conditions
  input  wire logic [11:0] err_mask,          // Nonvolatile error masks
  input  wire logic        warn_any,          // Any unmasked warning flag
  input  wire logic        hard_reset_done,   // Hard reset just happened
  input  wire logic        nvm_loaded,        // Nonvolatile memory loaded
  input  wire logic [1:0]  nvm_die_identifier,        // Die_identifier from memory
  input  wire logic        rotation_direction,// Hysteresis direction
  input  wire logic        logic_selftest_running,    // Logic self-test on
  input  wire logic        frontend_selftest_running, // Front-end test on
  input  wire logic        boot_in_progress,  // Boot sequence running
  input  wire logic        boot_complete,     // Load and start-up tests done
  input  wire logic        loop_locked,       // Tracking loop locked
  input  wire logic        action_selector_complete,  // Action_selector action finished
  output logic             action_start,      // Pulse: launch action
  output asr_action_e      action_kind,       // Kind of launched action
  output logic [3:0]       action_selector,   // Selector as written
  output logic             warning_clear      // Pulse: clear warnings
);

  asr_frame_s     frame;
  logic           frame_valid;
  logic [15:0]    tx_word;
  logic [11:0]    err_flags;
  logic [11:0]    err_set;
  logic           err_capture;
  logic           err_clear;
  logic           error_summary_bit;
  logic           undervoltage_summary_bit;
  logic [15:0]    angle_word;
  logic [15:0]    status_word;
  logic [15:0]    error_word;
  logic [1:0]     die_identifier;
  logic           action_selector_done;
  logic           boot_done;
  logic           boot_complete_q;
  logic           is_read;
  logic           wr_ctrl;
  logic           wr_trig;
  logic           trig_ok;
  asr_action_e    trig_kind;
  asr_act_state_e act_state;
  asr_act_state_e next_act_state;
  logic           launch;

  ////////////////////////////////////////////////////////////////////////
  // Serial port slave
  asr_link u_link (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .link_sclk   (link_sclk),
    .link_cs_n   (link_cs_n),
    .link_mosi   (link_mosi),
    .tx_word     (tx_word),
    .miso_out    (link_miso_out),
    .miso_oe     (link_miso_oe),
    .frame_valid (frame_valid),
    .frame       (frame)
  );

  // Frame decode
  assign is_read = frame_valid & ~frame.write;
  assign wr_ctrl = frame_valid & frame.write & (frame.addr == `ASR_OFS_CTRL);
  assign wr_trig = frame_valid & frame.write & (frame.addr == `ASR_OFS_TRIG);

  ////////////////////////////////////////////////////////////////////////
  // Error flags: live conditions in, latched in the bank
  always_comb begin
    err_set = err_cond;
    err_set[`ASR_ERR_WAR] = warn_any & ~err_mask[`ASR_ERR_WAR];
    err_set[`ASR_ERR_UVD] = err_cond.supply_undervoltage;
    err_set[`ASR_ERR_UVA] = err_cond.regulator_undervoltage;
    err_set[0] = hard_reset_done;
  end

  // Capture on an error read, clear on the error-clear control bit
  assign err_capture = is_read & (frame.addr[5:1] == `ASR_OFS_ERR >> 1);
  assign err_clear   = wr_ctrl & frame.data[`ASR_CTRL_CLE];

  asr_err_bank #(
    .N         (`ASR_ERR_BITS),
    .RESET_VAL (`ASR_ERR_RESET)
  ) u_err (
    .clock   (clock),
    .sys_rst (sys_rst),
    .set_in  (err_set),
    .capture (err_capture),
    .clear   (err_clear),
    .flags   (err_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // Angle word assembly; undervoltage bit is live, error summary follows the masked latched flags and the live warn_any
  assign error_summary_bit = |(err_flags & ~err_mask) | warn_any;
  assign undervoltage_summary_bit =
    (err_cond.supply_undervoltage & ~err_mask[`ASR_ERR_UVD]) |
    (err_cond.regulator_undervoltage & ~err_mask[`ASR_ERR_UVA]);
  assign angle_word = {1'b0, error_summary_bit, undervoltage_summary_bit,
                       ~^{error_summary_bit, undervoltage_summary_bit, angle_value},
                       angle_value};

  // Status and error words with their id nibbles
  assign status_word = {`ASR_ID_STA, 2'b00, die_identifier, rotation_direction, 1'b0,
                        action_selector_done, boot_done,
                        logic_selftest_running, frontend_selftest_running,
                        boot_in_progress, loop_locked & boot_complete};
  assign error_word  = {`ASR_ID_ERR, err_flags};

  ////////////////////////////////////////////////////////////////////////
  // Read mux; odd addresses fold onto their word, unmapped reads give zero
  function automatic logic [15:0] read_mux(input logic [5:0] addr, input logic [15:0] angle_reading,
                                           input logic [15:0] device_status, input logic [15:0] err,
                                           input logic [3:0] sel);
    logic [15:0] val;
    val = 16'h0000;
    case (addr[5:1])
      `ASR_OFS_ANG >> 1:  val = angle_reading;
      `ASR_OFS_STA >> 1:  val = device_status;
      `ASR_OFS_ERR >> 1:  val = err;
      `ASR_OFS_CTRL >> 1: val = {sel, 12'h000};
      default:            val = 16'h0000;
    endcase
    return val;
  endfunction

  // Response word is frozen at frame end, so the error capture matches it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_word <= 16'h0000;
    end else if (frame_valid) begin
      tx_word <= is_read ? read_mux(frame.addr, angle_word, status_word, error_word,
                                    action_selector) : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Die identifier follows memory once loaded
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      die_identifier <= 2'b00;
    end else if (nvm_loaded) begin
      die_identifier <= nvm_die_identifier;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger decode: byte must match the selector loaded beforehand
  always_comb begin
    trig_ok   = 1'b0;
    trig_kind = ASR_ACT_NONE;
    case (frame.data)
      `ASR_TRIG_SELFTEST: begin
        trig_ok   = action_selector == `ASR_SEL_FRONTEND || action_selector == `ASR_SEL_LOGIC ||
                    action_selector == `ASR_SEL_BOTH;
        trig_kind = ASR_ACT_SELFTEST;
      end
      `ASR_TRIG_TURNS: begin
        trig_ok   = action_selector == `ASR_SEL_TURNS;
        trig_kind = ASR_ACT_TURNS;
      end
      `ASR_TRIG_HARD: begin
        trig_ok   = action_selector == `ASR_SEL_HARD;
        trig_kind = ASR_ACT_HARD;
      end
      default: begin
        trig_ok   = 1'b0;
        trig_kind = ASR_ACT_NONE;
      end
    endcase
  end

  // Sequencer: one action at a time; triggers while busy are dropped
  always_comb begin
    next_act_state = act_state;
    case (act_state)
      ASR_IDLE: if (wr_trig && trig_ok) next_act_state = ASR_BUSY;
      ASR_BUSY: if (action_selector_complete) next_act_state = ASR_IDLE;
      default:  next_act_state = ASR_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      act_state <= ASR_IDLE;
    end else begin
      act_state <= next_act_state;
    end
  end

  // Accepted trigger; busy check keeps one action at a time
  assign launch = act_state == ASR_IDLE && wr_trig && trig_ok;

  // Launch pulse and kind
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      action_start <= 1'b0;
      action_kind  <= ASR_ACT_NONE;
    end else begin
      action_start <= launch;
      if (launch) begin
        action_kind <= trig_kind;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Selector: written by host, returns to zero once the action finishes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      action_selector <= 4'h0;
    end else if (act_state == ASR_BUSY && action_selector_complete) begin
      action_selector <= 4'h0;
    end else if (wr_ctrl && act_state == ASR_IDLE) begin
      action_selector <= frame.data[`ASR_CTRL_SEL_HI:`ASR_CTRL_SEL_LO];
    end
  end

  // Warning clear is handed to the warning block
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      warning_clear <= 1'b0;
    end else begin
      warning_clear <= wr_ctrl & frame.data[`ASR_CTRL_CLW];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Action_selector-done: completion sets and wins over a same-cycle clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      action_selector_done <= 1'b0;
    end else if (act_state == ASR_BUSY && action_selector_complete) begin
      action_selector_done <= 1'b1;
    end else if (launch) begin
      action_selector_done <= 1'b0;
    end else if (wr_ctrl && frame.data[`ASR_CTRL_CLS]) begin
      action_selector_done <= 1'b0;
    end
  end

  // Boot-done: set on the rise of boot completion, set beats clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      boot_complete_q <= 1'b0;
      boot_done       <= 1'b0;
    end else begin
      boot_complete_q <= boot_complete;
      if (boot_complete && !boot_complete_q) begin
        boot_done <= 1'b1;
      end else if (wr_ctrl && frame.data[`ASR_CTRL_CLS]) begin
        boot_done <= 1'b0;
      end
    end
  end

endmodule // asr_regs
`default_nettype wire

// [verif/asr_regs_checker.sv]
// Concurrent checks on the link and action ports of asr_regs.
// Assumes one clock domain; bound to asr_regs at the foot.
`timescale 1ns/1ps
`default_nettype none
module asr_regs_checker
  import asr_pkg::*;
(
  input wire logic        clock,            // System clock
  input wire logic        sys_rst,          // Reset, active high
  input wire logic        link_cs_n,        // Host select
  input wire logic        link_miso_out,    // Data out level
  input wire logic        link_miso_oe,     // Data out enable
  input wire logic        action_selector_complete, // Action finished
  input wire logic        action_start,     // Launch pulse
  input wire asr_action_e action_kind,      // Launched kind
  input wire logic [3:0]  action_selector,  // Selector
  input wire logic        warning_clear     // Warning clear pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // Launch and selector move only on accepted frames or completion
  a_start_pulse: assert property (action_start |=> !action_start)
    else $error("start pulse too long");
  a_kind_valid: assert property (action_start |-> action_kind != ASR_ACT_NONE)
    else $error("start with no kind");
  a_kind_moves: assert property ($changed(action_kind) |-> action_start)
    else $error("kind moved without start");
  a_start_frame: assert property (action_start |-> link_cs_n && $past(link_cs_n, 3))
    else $error("start inside a frame");
  a_sel_moves: assert property ($changed(action_selector) |-> link_cs_n || $past(action_selector_complete))
    else $error("selector moved without cause");
  a_wclr_pulse: assert property (warning_clear |-> link_cs_n ##1 !warning_clear)
    else $error("warning clear bad");
  // Data line released and low once select has stood high a while
  a_idle_quiet: assert property (link_cs_n [*6] |-> !link_miso_oe && !link_miso_out)
    else $error("data line driven while idle");
  a_oe_frame: assert property (!link_cs_n [*6] |-> link_miso_oe)
    else $error("data line not driven in frame");
  c_hard: cover property (action_start && action_kind == ASR_ACT_HARD);
  c_wclr: cover property (warning_clear);
  c_frame: cover property ($fell(link_miso_oe));
endmodule // asr_regs_checker
bind asr_regs asr_regs_checker asr_regs_checker_i (.clock, .sys_rst, .link_cs_n, .link_miso_out,
  .link_miso_oe, .action_selector_complete, .action_start, .action_kind, .action_selector, .warning_clear);
`default_nettype wire

// [verif/asr_host.sv]
// Host model for the serial register port: 16-bit frames, MSB first.
// Assumes the device samples data on the rising link clock edge.
`timescale 1ns/1ps
`default_nettype none
module asr_host (
  output logic      link_sclk,     // Link clock, idles low
  output logic      link_cs_n,     // Select, active low
  output logic      link_mosi,     // Data to device
  input  wire logic link_miso_out, // Device data level
  input  wire logic link_miso_oe   // Device drives data
);
  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
    link_mosi = 1'b0;
  end
  // One frame at 64 ns period; clock stands still between frames
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    link_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      link_mosi = w[i];
      #32 link_sclk = 1'b1;
      r[i] = link_miso_oe ? link_miso_out : ~link_miso_out; // Undriven line reads as junk
      #32 link_sclk = 1'b0;
    end
    #32 link_cs_n = 1'b1;
    link_mosi = ~link_mosi;
    #40;
  endtask
endmodule // asr_host
`default_nettype wire

// [verif/asr_regs_tb.sv]
// Bench for asr_regs: table of reads, then actions, clears and reset.
// Assumes asr_host drives the link and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module asr_regs_tb
  import asr_pkg::*;
;
  typedef struct packed {
    logic [11:0] angle_reading, mask;
    logic [2:0]  wur; // Warning, supply undervoltage, rotation
    logic [1:0]  die;
    logic [3:0]  st;  // Logic test, front-end test, boot, lock
    logic [1:0]  eu;  // Expected summary and undervoltage bits
  } asr_row_s;
  logic        clock, sys_rst, link_sclk, link_cs_n, link_mosi, link_miso_out, link_miso_oe;
  logic [11:0] angle_value, err_mask;
  asr_err_s    err_cond;
  logic        warn_any, hard_reset_done, nvm_loaded, rotation_direction, logic_selftest_running;
  logic        frontend_selftest_running, boot_in_progress, boot_complete, loop_locked, action_selector_complete;
  logic [1:0]  nvm_die_identifier;
  logic        action_start, warning_clear;
  asr_action_e action_kind, last_kind;
  logic [3:0]  action_selector;
  logic [15:0] r;
  int          n_fail, n_compared, n_start, n_wclr, n;
  asr_row_s    rows [5] = '{'{12'h000, 12'hFFF, 3'h0, 2'h0, 4'h0, 2'h0}, '{12'hFFF, 12'hFFF, 3'h5, 2'h3, 4'h8, 2'h2},
    '{12'h555, 12'hFFF, 3'h2, 2'h1, 4'h4, 2'h0}, '{12'hA5A, 12'hFF7, 3'h3, 2'h2, 4'h2, 2'h3},
    '{12'h800, 12'hFFE, 3'h0, 2'h0, 4'h1, 2'h2}};
  logic [15:0] acts [5] = '{16'h9B91, 16'hAB91, 16'hBB91, 16'h4462, 16'h75A3}; // Selector, trigger, kind
  asr_host asr_host_i (.link_sclk, .link_cs_n, .link_mosi, .link_miso_out, .link_miso_oe);
  asr_regs asr_regs_i (.clock, .sys_rst, .link_sclk, .link_cs_n, .link_mosi, .link_miso_out, .link_miso_oe,
    .angle_value, .err_cond, .err_mask, .warn_any, .hard_reset_done, .nvm_loaded, .nvm_die_identifier,
    .rotation_direction, .logic_selftest_running, .frontend_selftest_running, .boot_in_progress,
    .boot_complete, .loop_locked, .action_selector_complete, .action_start, .action_kind, .action_selector,
    .warning_clear);
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic fr(input logic [15:0] w);
    asr_host_i.xfer(w, r);
  endtask
  function automatic logic [15:0] angw(input logic [1:0] eu, input logic [11:0] a);
    return {1'b0, eu, ~^{eu, a}, a}; // Parity makes the ones odd
  endfunction
  task automatic print_verdict();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Pulses are counted here since a frame outlasts them
  always @(posedge clock) begin
    if (action_start) begin
      n_start++;
      last_kind = action_kind;
    end
    if (warning_clear) n_wclr++;
  end
  initial begin
    #300000;
    n_fail++;
    print_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    {angle_value, err_mask, err_cond, warn_any, hard_reset_done, nvm_die_identifier, rotation_direction} = '0;
    {logic_selftest_running, frontend_selftest_running, boot_in_progress, boot_complete} = '0;
    {loop_locked, action_selector_complete} = '0;
    nvm_loaded = 1'b1;
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    boot_complete = 1'b1;
    foreach (rows[i]) begin
      @(negedge clock);
      {angle_value, err_mask, nvm_die_identifier} = {rows[i].angle_reading, rows[i].mask, rows[i].die};
      {warn_any, err_cond.supply_undervoltage, rotation_direction} = rows[i].wur;
      {logic_selftest_running, frontend_selftest_running, boot_in_progress, loop_locked} = rows[i].st;
      fr(16'h2000);
      fr(16'h2200);
      chk("angle word", angw(rows[i].eu, rows[i].angle_reading), r);
      fr(16'h2000);
      chk("status word", {4'h8, 2'h0, rows[i].die, rows[i].wur[0], 3'h1, rows[i].st}, r);
    end
    foreach (acts[k]) begin
      n = n_start;
      fr({8'h5E, acts[k][15:12], 4'h0});
      fr({8'h5F, acts[k][11:4]});
      chk("start count", 16'(n + 1), 16'(n_start));
      chk("action kind", {14'h0, acts[k][1:0]}, {14'h0, last_kind});
      fr(16'h2200);
      @(negedge clock);
      action_selector_complete = 1'b1;
      @(negedge clock);
      action_selector_complete = 1'b0;
      fr(16'h2200);
      chk("done while busy", 16'h0, {15'h0, r[5]});
      fr(16'h2000);
      chk("done after finish", 16'h1, {15'h0, r[5]});
      chk("selector after finish", 16'h0, {12'h0, action_selector});
    end
    fr(16'h5EB0);
    fr(16'h1F00);
    fr(16'h3000);
    chk("control read", 16'hB000, r);
    fr(16'h5E40);
    chk("unmapped read", 16'h0, r);
    n = n_start;
    fr(16'h5FB9);
    fr(16'hDEB0);
    chk("wrong trigger", 16'(n), 16'(n_start));
    chk("refused frame", 16'h4, {12'h0, action_selector});
    fr(16'h5E04);
    fr(16'h2200);
    fr(16'h2000);
    chk("done bits cleared", 16'h0, {14'h0, r[5:4]});
    // Every error source but the reset flag and zero-crossing once, then zero-crossing after the read
    @(negedge clock);
    {err_mask, warn_any, err_cond} = {12'h0, 1'b1, 12'h7BE};
    @(negedge clock);
    {warn_any, err_cond} = '0;
    fr(16'h2400);
    @(negedge clock);
    err_cond.zero_crossing_timeout = 1'b1;
    @(negedge clock);
    err_cond = '0;
    n = n_wclr;
    fr(16'h5E03);
    chk("error word", 16'hAFBF, r);
    chk("warning clear", 16'(n + 1), 16'(n_wclr));
    fr(16'h2400);
    fr(16'h2000);
    chk("error after clear", 16'hA040, r);
    hard_reset_done = 1'b1;
    fr(16'h2400);
    hard_reset_done = 1'b0;
    fr(16'h2000);
    chk("reset flag", 16'hA041, r);
    @(negedge clock);
    sys_rst = 1'b1;
    repeat (16) @(negedge clock);
    chk("outputs in reset", 16'h0, {action_start, warning_clear, link_miso_oe, link_miso_out, action_kind,
      action_selector, 6'h0});
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    fr(16'h2400);
    chk("first reply", 16'h0, r);
    fr(16'h2000);
    chk("error after reset", 16'hA001, r);
    print_verdict();
  end
endmodule // asr_regs_tb
`default_nettype wire
